// ===== hdl/fsr_map.svh
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
// =====================================================================
// Command codes
`define FSR_OP_READ_STATUS  8'h05
`define FSR_OP_WRITE_S1     8'h01
// =====================================================================
// Status byte one field positions
`define FSR_B_LOCK          7
`define FSR_B_RSVD          6
`define FSR_B_ERR           5
`define FSR_B_WPP           4
`define FSR_B_SWP_HI        3
`define FSR_B_SWP_LO        2
`define FSR_B_WEL           1
`define FSR_B_BUSY          0
// =====================================================================
// Reset values
`define FSR_LOCK_RST        1'h0
`define FSR_ERR_RST         1'h0
`define FSR_WEL_RST         1'h0
`define FSR_S1_RST          8'h0C
`define FSR_SO_RST          1'h0
`define FSR_OEN_RST         1'h1
// =====================================================================
// Timing counts
`define FSR_BIT_LAST        3'h7
`define FSR_BIT_FIRST       3'h0
`endif

// ===== hdl/fsr_pkg.sv
package fsr_pkg;
    typedef enum logic [2:0] {
        FSR_IDLE  = 3'b000,
        FSR_CMD   = 3'b001,
        FSR_READ  = 3'b010,
        FSR_WDATA = 3'b011,
        FSR_SKIP  = 3'b100
    } fsr_state_t;
endpackage

// ===== hdl/fsr_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_map.svh"
module fsr_status
    import fsr_pkg::*;
#(
    parameter logic [7:0] READ_OPCODE  = `FSR_OP_READ_STATUS,
    parameter logic [7:0] WRITE_OPCODE = `FSR_OP_WRITE_S1
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // Serial link pins
    input  wire logic       SCK,
    input  wire logic       CSN,
    input  wire logic       SI,
    output var  logic       SO,
    output var  logic       SO_OEN,
    // Write-protect pin, active low
    input  wire logic       WPN,
    // Core engine status
    input  wire logic       BUSY,
    input  wire logic       WREN_SET,
    input  wire logic       WEL_CLR,
    input  wire logic       SOFT_RST,
    input  wire logic       OP_DONE,
    input  wire logic       OP_FAIL,
    input  wire logic       OP_ABORT,
    input  wire logic [1:0] PROT_SUMMARY,
    input  wire logic [7:0] STATUS2_IN,
    // Status view
    output var  logic [7:0] STATUS_BYTE1
);

    // =================================================================
    // Parameter checks
    if (READ_OPCODE == WRITE_OPCODE) begin : g_chk
        $error("fsr_status: read and write opcodes must differ");
    end

    // =================================================================
    // Pin synchronisers
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       sck_prev_r;
    logic       sck_s;
    logic       cs_act;
    logic       si_s;
    logic       wp_n_s;
    logic       sck_rise;
    logic       sck_fall;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_r    <= 4'hB;
            sync2_r    <= 4'hB;
            sck_prev_r <= 1'h1;
        end else begin
            sync1_r    <= {WPN, SI, CSN, SCK};
            sync2_r    <= sync1_r;
            sck_prev_r <= sync2_r[0];
        end
    end

    assign sck_s    = sync2_r[0];
    assign cs_act   = !sync2_r[1];
    assign si_s     = sync2_r[2];
    assign wp_n_s   = sync2_r[3];
    assign sck_rise = sck_s && !sck_prev_r;
    assign sck_fall = !sck_s && sck_prev_r;

    // =================================================================
    // Command framing
    fsr_state_t state_r;
    fsr_state_t state_nxt;
    logic [2:0] rx_cnt_r;
    logic [6:0] rx_sh_r;
    logic [7:0] rx_byte;
    logic       rx_done;
    logic       wr_commit;

    assign rx_byte   = {rx_sh_r, si_s};
    assign rx_done   = sck_rise && (rx_cnt_r == `FSR_BIT_LAST);
    assign wr_commit = (state_r == FSR_WDATA) && rx_done;

    always_comb begin
        state_nxt = state_r;
        if (!cs_act) begin
            state_nxt = FSR_IDLE;
        end else begin
            case (state_r)
                FSR_IDLE: begin
                    state_nxt = FSR_CMD;
                end
                FSR_CMD: begin
                    // No busy gating: reads go through mid-operation
                    if (rx_done && rx_byte == READ_OPCODE) begin
                        state_nxt = FSR_READ;
                    end else if (rx_done && rx_byte == WRITE_OPCODE) begin
                        state_nxt = FSR_WDATA;
                    end else if (rx_done) begin
                        state_nxt = FSR_SKIP;
                    end
                end
                FSR_WDATA: begin
                    if (rx_done) begin
                        state_nxt = FSR_SKIP;
                    end
                end
                FSR_READ: state_nxt = FSR_READ;
                FSR_SKIP: state_nxt = FSR_SKIP;
                default:  state_nxt = FSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= FSR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_cnt_r <= `FSR_BIT_FIRST;
            rx_sh_r  <= 7'h00;
        end else if (state_r == FSR_IDLE) begin
            rx_cnt_r <= `FSR_BIT_FIRST;
            rx_sh_r  <= 7'h00;
        end else if (sck_rise) begin
            rx_cnt_r <= rx_cnt_r + 3'h1;
            rx_sh_r  <= rx_byte[6:0];
        end
    end

    // =================================================================
    // Status flags
    logic lock_r;
    logic err_r;
    logic wel_r;
    logic lock_ok;

    // Clearing the lock needs the write-protect pin released
    assign lock_ok = wel_r && (wp_n_s || rx_byte[`FSR_B_LOCK]);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            lock_r <= `FSR_LOCK_RST;
        end else if (wr_commit && lock_ok) begin
            lock_r <= rx_byte[`FSR_B_LOCK];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            err_r <= `FSR_ERR_RST;
        end else if (OP_DONE && !OP_ABORT) begin
            err_r <= OP_FAIL;
        end
    end

    // Set wins over every clear so a late enable is never lost
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wel_r <= `FSR_WEL_RST;
        end else if (WREN_SET) begin
            wel_r <= 1'h1;
        end else if (WEL_CLR || SOFT_RST || wr_commit) begin
            wel_r <= 1'h0;
        end
    end

    // =================================================================
    // Status byte assembly
    logic [7:0] s1_nxt;
    logic [7:0] s2_nxt;

    always_comb begin
        s1_nxt                            = 8'h00;
        s1_nxt[`FSR_B_LOCK]               = lock_r;
        s1_nxt[`FSR_B_ERR]                = err_r;
        s1_nxt[`FSR_B_WPP]                = wp_n_s;
        s1_nxt[`FSR_B_SWP_HI:`FSR_B_SWP_LO] = PROT_SUMMARY;
        s1_nxt[`FSR_B_WEL]                = wel_r;
        s1_nxt[`FSR_B_BUSY]               = BUSY;
        s2_nxt                            = {STATUS2_IN[7:1], BUSY};
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            STATUS_BYTE1 <= `FSR_S1_RST;
        end else begin
            STATUS_BYTE1 <= s1_nxt;
        end
    end

    // =================================================================
    // Serial output
    logic [2:0] tx_idx_r;
    logic       tx_sel_r;
    logic [7:0] tx_byte_r;
    logic       tx_step;
    logic       tx_load;
    logic [7:0] tx_fresh;

    assign tx_step  = (state_r == FSR_READ) && sck_fall && cs_act;
    assign tx_load  = tx_step && (tx_idx_r == `FSR_BIT_LAST);
    assign tx_fresh = tx_sel_r ? s2_nxt : s1_nxt;

    // Each byte is sampled when its first bit leaves, never earlier
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_idx_r  <= `FSR_BIT_LAST;
            tx_sel_r  <= 1'h0;
            tx_byte_r <= 8'h00;
        end else if (state_r != FSR_READ) begin
            tx_idx_r  <= `FSR_BIT_LAST;
            tx_sel_r  <= 1'h0;
        end else if (tx_step) begin
            tx_idx_r <= tx_idx_r - 3'h1;
            if (tx_load) begin
                tx_byte_r <= tx_fresh;
            end
            if (tx_idx_r == `FSR_BIT_FIRST) begin
                tx_sel_r <= !tx_sel_r;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SO     <= `FSR_SO_RST;
            SO_OEN <= `FSR_OEN_RST;
        end else if (!cs_act || state_r != FSR_READ) begin
            SO_OEN <= 1'h1;
        end else if (tx_step) begin
            SO_OEN <= 1'h0;
            SO     <= tx_load ? tx_fresh[7] : tx_byte_r[tx_idx_r];
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    release_float_a: assert property (
        !cs_act |=> SO_OEN)
        else $error("output not floated after chip select release");
    drive_read_a: assert property (
        tx_step |=> !SO_OEN)
        else $error("output not driven during status read");
    msb_first_a: assert property (
        tx_load |=> SO == tx_byte_r[7])
        else $error("first bit of byte is not its msb");
    fresh_byte_a: assert property (
        (tx_load && !tx_sel_r) |=> tx_byte_r == STATUS_BYTE1)
        else $error("byte one not freshly sampled");
    busy_both_a: assert property (
        tx_load |=> tx_byte_r[0] == $past(BUSY))
        else $error("busy not refreshed in output byte");
    byte_wrap_a: assert property (
        (tx_step && tx_idx_r == `FSR_BIT_FIRST) |=> tx_sel_r != $past(tx_sel_r))
        else $error("byte select did not alternate");
    reserved_zero_a: assert property (
        !STATUS_BYTE1[`FSR_B_RSVD])
        else $error("reserved bit reads one");
    lock_hold_a: assert property (
        (!wp_n_s && lock_r) |=> lock_r)
        else $error("lock cleared while write-protect asserted");
    wel_gate_a: assert property (
        (wr_commit && !wel_r) |=> $stable(lock_r))
        else $error("status write accepted without write enable");
    err_abort_a: assert property (
        (OP_ABORT && !$past(OP_DONE && !OP_ABORT)) |=> $stable(err_r))
        else $error("error flag moved on an aborted operation");
    err_update_a: assert property (
        (OP_DONE && !OP_ABORT) |=> err_r == $past(OP_FAIL))
        else $error("error flag not updated after operation");
    wel_write_a: assert property (
        (wr_commit && !WREN_SET) |=> !wel_r ##1 !STATUS_BYTE1[`FSR_B_WEL])
        else $error("write enable not cleared after status write");

    read_entry_c:  cover property (state_r == FSR_CMD ##1 state_r == FSR_READ);
    second_byte_c: cover property (tx_load && tx_sel_r);
    lock_set_c:    cover property (wr_commit && lock_ok ##1 lock_r);
    cut_short_c:   cover property (tx_step && tx_idx_r == 3'h3 ##[1:40] !cs_act);

endmodule // fsr_status
`default_nettype wire

// ===== tb/fsr_host.sv
`timescale 1ns/100ps
`default_nettype none
module fsr_host (
    // Clock
    input  wire logic clk,
    // Link pins
    output var  logic sck,
    output var  logic csn,
    output var  logic si,
    input  wire logic so,
    input  wire logic so_oen
);
    logic last_so;
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        si = 1'b0;
        last_so = 1'b0;
    end
    // =========================================================
    // Frame: opcode, then n clocks; wd leaves MSB first
    task automatic xfer(input logic [7:0] op, input logic [7:0] wd,
                        input int n, output logic [31:0] rd,
                        output logic oe);
        logic [15:0] sh;
        rd = '0;
        oe = 1'b0;
        sh = {op, wd};
        @(posedge clk) csn <= 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            // Beyond the data byte SI toggles so nothing stale is seen
            @(posedge clk) si <= (i < 16) ? sh[15 - i] : ~si;
            // Eight CLK per SCK period: four low, four high
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
            if (i >= 8) begin
                // A floating line shows the inverse of its last level
                last_so = so_oen ? ~last_so : so;
                rd = {rd[30:0], last_so};
                oe = oe | !so_oen;
            end
            @(posedge clk) sck <= 1'b0;
        end
        @(posedge clk) csn <= 1'b1;
    endtask
endmodule // fsr_host
`default_nettype wire

// ===== tb/tb_flash_status_register_read.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module tb_flash_status_register_read;
    logic        clk, rstn, sck, csn, si, so, so_oen;
    logic        wpn, busy;
    logic [5:0]  ev;
    logic [1:0]  prot;
    logic [7:0]  s2, sb1;
    logic [31:0] rd;
    logic        oe;
    int          failures, num_checks;
    logic [11:0] rows [4] = '{12'hB1C, 12'h401, 12'hD15, 12'h208};

    fsr_status u_dut (.CLK(clk), .RSTN(rstn), .SCK(sck), .CSN(csn),
        .SI(si), .SO(so), .SO_OEN(so_oen), .WPN(wpn), .BUSY(busy),
        .WREN_SET(ev[5]), .WEL_CLR(ev[4]), .SOFT_RST(ev[3]),
        .OP_DONE(ev[2]), .OP_FAIL(ev[1]), .OP_ABORT(ev[0]),
        .PROT_SUMMARY(prot), .STATUS2_IN(s2), .STATUS_BYTE1(sb1));
    fsr_host u_host (.clk(clk), .sck(sck), .csn(csn), .si(si),
        .so(so), .so_oen(so_oen));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // =========================================================
    // Helpers
    task automatic stop_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd_stat(input int n);
        u_host.xfer(8'h05, 8'h00, n, rd, oe);
        repeat (6) @(posedge clk);
        `CHK(so_oen, 1'b1)
        `CHK(oe, 1'b1)
    endtask
    task automatic wr(input logic [7:0] d);
        u_host.xfer(8'h01, d, 8, rd, oe);
        repeat (6) @(posedge clk);
    endtask
    // One-cycle core event pulse, then let the status flop follow
    task automatic core(input logic [5:0] v);
        @(posedge clk) ev <= v;
        @(posedge clk) ev <= '0;
        repeat (3) @(posedge clk);
    endtask
    // =========================================================
    // Watchdog: the whole run needs well under 0.5 ms
    initial begin
        #1000000;
        failures++;
        stop_test();
    end
    // =========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        wpn = 1'b1;
        busy = 1'b0;
        ev = '0;
        prot = 2'b11;
        s2 = 8'hA5;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        `CHK(sb1, 8'h0C)
        `CHK(so_oen, 1'b1)
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        $display("reset done");
        foreach (rows[i]) begin
            @(posedge clk) {wpn, busy, prot} <= rows[i][11:8];
            repeat (4) @(posedge clk);
            rd_stat(16);
            `CHK(rd[15:8], rows[i][7:0])
            `CHK(rd[7:0], {7'h52, rows[i][10]})
            `CHK(sb1, rows[i][7:0])
            $display("row %0d done", i);
        end
        @(posedge clk) {wpn, busy, prot} <= 4'b1011;
        core(6'b100000);
        `CHK(sb1, 8'h1E)
        wr(8'hC3);
        `CHK(sb1, 8'h9C)
        wr(8'h00);
        `CHK(sb1, 8'h9C)
        @(posedge clk) wpn <= 1'b0;
        core(6'b100000);
        wr(8'h00);
        `CHK(sb1, 8'h8C)
        core(6'b100000);
        core(6'b001000);
        `CHK(sb1, 8'h8C)
        @(posedge clk) wpn <= 1'b1;
        core(6'b100000);
        wr(8'h7F);
        `CHK(sb1, 8'h1C)
        $display("write test done");
        core(6'b000110);
        `CHK(sb1, 8'h3C)
        core(6'b000111);
        `CHK(sb1, 8'h3C)
        core(6'b000100);
        `CHK(sb1, 8'h1C)
        $display("error flag test done");
        // Busy rises after byte two is sampled, before byte one repeats
        fork
            rd_stat(32);
            begin
                repeat (180) @(posedge clk);
                busy <= 1'b1;
            end
        join
        `CHK(rd, 32'h1CA41DA5)
        $display("repeat test done");
        @(posedge clk) busy <= 1'b0;
        u_host.xfer(8'h05, 8'h00, 5, rd, oe);
        repeat (6) @(posedge clk);
        rd_stat(8);
        `CHK(rd[7:0], 8'h1C)
        u_host.xfer(8'h9F, 8'h00, 8, rd, oe);
        `CHK(oe, 1'b0)
        $display("frame test done");
        // Clear pulse drops the enable; a set in the same cycle wins
        core(6'b100000);
        core(6'b010000);
        `CHK(sb1, 8'h1C)
        core(6'b110000);
        `CHK(sb1, 8'h1E)
        wr(8'h80);
        core(6'b100000);
        `CHK(sb1, 8'h9E)
        // Mid-run reset drops both the lock and the enable
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(sb1, 8'h0C)
        `CHK(so_oen, 1'b1)
        @(posedge clk) rstn <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(sb1, 8'h1C)
        $display("reset test done");
        stop_test();
    end
endmodule // tb_flash_status_register_read
`default_nettype wire
